// ### dv/sdl_spi_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sdl_spi_peer (
    // serial lines toward the slave
    output logic      sck,
    output logic      ss_n,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sck  = 1'b0;
        ss_n = 1'b1;
        sdi  = 1'b0;
    end

    task automatic sel(input logic lvl);
        ss_n = lvl;
    endtask : sel

    // one word msb first, 160 ns clock, idle low between frames
    task automatic xfer(input logic [7:0] w, output logic [7:0] got);
        ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdi = w[i];
            #80 sck = 1'b1;
            got[i] = sdo;
            #80 sck = 1'b0;
        end
        // released data line must not show a stale bit
        #80 sdi = ~sdi;
        ss_n = 1'b1;
        #80;
    endtask : xfer
endmodule : sdl_spi_peer
`default_nettype wire

// ### dv/test_spi_status_dma_error_logic.sv
`timescale 1ns/1ns
`default_nettype none
module test_spi_status_dma_error_logic;
    import sdl_pkg::*;
    logic ref_clk, reset, clk_en, sck_pin, slave_select_pin, sdi_pin, sdo_o, sdo_oe;
    logic ctrl1_wr, ctrl1_enable_wdata, ctrl1_master_wdata, ctrl1_check_wdata;
    logic hw_select_mode, internal_select_level, rx_only_mode, tx_dma_req_enable;
    logic rx_dma_req_enable, error_irq_enable, tx_empty_irq_enable, rx_full_irq_enable;
    logic data_wr, data_rd, status_rd, status_wr, status_wr_mismatch, dma_last_word;
    logic tx_dma_req, rx_dma_req, interface_enable_bit, master_select_bit, check_calc_enable;
    logic tx_buffer_empty_flag, rx_buffer_full_flag, transfer_busy_flag, master_fault_flag;
    logic overrun_flag, check_mismatch_flag, spi_irq;
    logic [7:0] data_wdata, data_rdata, tx_check_value, rx_check_value, tw, rw, got;
    integer seed = 64;
    int     fails = 0;
    int     tests_run = 0;

    sdl_core #(.WORD_BITS(8)) dut_u (.ref_clk, .reset, .clk_en, .sck_pin, .slave_select_pin,
        .sdi_pin, .sdo_o, .sdo_oe, .ctrl1_wr, .ctrl1_enable_wdata, .ctrl1_master_wdata,
        .ctrl1_check_wdata, .hw_select_mode, .internal_select_level, .rx_only_mode,
        .tx_dma_req_enable, .rx_dma_req_enable, .error_irq_enable, .tx_empty_irq_enable,
        .rx_full_irq_enable, .data_wr, .data_wdata, .data_rd, .data_rdata, .status_rd,
        .status_wr, .status_wr_mismatch, .tx_dma_req, .rx_dma_req, .dma_last_word,
        .interface_enable_bit, .master_select_bit, .check_calc_enable, .tx_buffer_empty_flag,
        .rx_buffer_full_flag, .transfer_busy_flag, .master_fault_flag, .overrun_flag,
        .check_mismatch_flag, .tx_check_value, .rx_check_value, .spi_irq);
    sdl_spi_peer m_u (.sck(sck_pin), .ss_n(slave_select_pin), .sdi(sdi_pin), .sdo(sdo_o));

    always #5 ref_clk = ~ref_clk;

    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask : step

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask : chk

    task automatic wr_ctrl(input logic en, input logic ms, input logic ck);
        step();
        {ctrl1_wr, ctrl1_enable_wdata, ctrl1_master_wdata, ctrl1_check_wdata} = {1'b1, en, ms, ck};
        step();
        ctrl1_wr = 1'b0;
    endtask : wr_ctrl

    task automatic pulse(input int k);
        step();
        {data_wr, data_rd, status_rd, status_wr, dma_last_word} = 5'h10 >> k;
        step();
        {data_wr, data_rd, status_rd, status_wr, dma_last_word} = 5'h00;
    endtask : pulse

    // bench model of the check accumulator from its initial state
    function automatic logic [7:0] crc(input logic [7:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    initial begin
        #400000;
        fails++;
        give_verdict();
    end

    initial begin
        {ref_clk, reset, clk_en, ctrl1_wr, ctrl1_enable_wdata, ctrl1_master_wdata} = 6'h18;
        {ctrl1_check_wdata, hw_select_mode, internal_select_level, rx_only_mode} = 4'h2;
        {tx_dma_req_enable, rx_dma_req_enable, error_irq_enable} = 3'h0;
        {tx_empty_irq_enable, rx_full_irq_enable, data_wr, data_rd, status_rd} = 5'h00;
        {status_wr, status_wr_mismatch, dma_last_word, data_wdata} = 11'h000;
        repeat (5) @(posedge ref_clk);
        #1 reset = 1'b0;
        chk("tx empty", 8'h01, tx_buffer_empty_flag);
        chk("busy", 8'h00, transfer_busy_flag);
        wr_ctrl(1'b1, 1'b0, 1'b0);
        for (int k = 0; k < 6; k++) begin
            {tx_dma_req_enable, rx_dma_req_enable, rx_full_irq_enable} = 3'($random(seed));
            tw = 8'($random(seed));
            rw = (k == 0) ? 8'hFF : ((k == 1) ? 8'h00 : 8'($random(seed)));
            data_wdata = tw;
            pulse(0);
            m_u.xfer(rw, got);
            step();
            chk("sdo word", tw, got);
            chk("rx word", rw, data_rdata);
            chk("rx full", 8'h01, rx_buffer_full_flag);
            chk("rx dma", {7'h0, rx_dma_req_enable}, rx_dma_req);
            chk("tx dma", {7'h0, tx_dma_req_enable}, tx_dma_req);
            chk("irq", {7'h0, rx_full_irq_enable}, spi_irq);
            pulse(1);
            chk("rx clear", 8'h00, rx_buffer_full_flag);
        end
        {error_irq_enable, rx_full_irq_enable} = 2'b10;
        m_u.xfer(8'hA5, got);
        m_u.xfer(8'h3C, got);
        step();
        chk("overrun", 8'h01, overrun_flag);
        chk("kept word", 8'hA5, data_rdata);
        chk("err irq", 8'h01, spi_irq);
        pulse(1);
        chk("overrun held", 8'h01, overrun_flag);
        pulse(2);
        chk("overrun clear", 8'h00, overrun_flag);
        chk("idle", 8'h02, {tx_buffer_empty_flag, transfer_busy_flag});
        wr_ctrl(1'b0, 1'b0, 1'b0);
        wr_ctrl(1'b0, 1'b0, 1'b1);
        wr_ctrl(1'b1, 1'b0, 1'b1);
        chk("tx acc init", 8'h00, tx_check_value);
        chk("rx acc init", 8'h00, rx_check_value);
        chk("check en", 8'h01, check_calc_enable);
        tx_dma_req_enable = 1'b1;
        tw = 8'($random(seed));
        rw = 8'($random(seed));
        data_wdata = tw;
        pulse(0);
        pulse(4);
        m_u.xfer(rw, got);
        step();
        chk("rx acc", crc(rw), rx_check_value);
        pulse(1);
        m_u.xfer(crc(rw) ^ 8'h5A, got);
        step();
        chk("check word out", crc(tw), got);
        chk("mismatch", 8'h01, check_mismatch_flag);
        status_wr_mismatch = 1'b1;
        pulse(3);
        chk("mismatch kept", 8'h01, check_mismatch_flag);
        status_wr_mismatch = 1'b0;
        pulse(3);
        chk("mismatch clear", 8'h00, check_mismatch_flag);
        hw_select_mode = 1'b1;
        wr_ctrl(1'b1, 1'b1, 1'b0);
        chk("master", 8'h01, master_select_bit);
        step();
        chk("sdo oe", 8'h01, sdo_oe);
        m_u.sel(1'b0);
        repeat (5) step();
        chk("fault", 8'h01, master_fault_flag);
        chk("fault en", 8'h00, interface_enable_bit);
        chk("fault ms", 8'h00, master_select_bit);
        chk("fault busy", 8'h00, transfer_busy_flag);
        chk("fault oe", 8'h00, sdo_oe);
        wr_ctrl(1'b1, 1'b1, 1'b0);
        chk("ignored set", 8'h00, {interface_enable_bit, master_select_bit});
        chk("fault stays", 8'h01, master_fault_flag);
        m_u.sel(1'b1);
        repeat (5) step();
        pulse(2);
        wr_ctrl(1'b0, 1'b0, 1'b0);
        chk("fault clear", 8'h00, master_fault_flag);
        {hw_select_mode, rx_only_mode} = 2'h1;
        wr_ctrl(1'b1, 1'b1, 1'b0);
        m_u.xfer(8'h5A, got);
        repeat (16) step();
        chk("rx only word", 8'h5A, data_rdata);
        wr_ctrl(1'b0, 1'b0, 1'b0);
        give_verdict();
    end
endmodule : test_spi_status_dma_error_logic
`default_nettype wire

// ### rtl/sdl_core.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R01: software resets checks: disable, toggle enable, enable
// R02: tx empty with enable raises tx dma request
// R03: rx full with enable raises rx dma request
// R04: separate enables gate tx and rx requests
// R05: check word exchanged automatically after dma data
// R06: full duplex: software waits rx, tx, busy
// R07: master rx-only: software waits n-1, one period
// R08: slave rx-only disable waits for word end
// R09: tx empty set when free, cleared by write
// R10: rx full until word read from data
// R11: busy from hardware, low in master rx-only
// R12: busy clears at end, disable, master fault
// R13: master continuous busy high, slave gaps low
// R14: select low while master sets fault flag
// R15: fault clears enable and master select
// R16: fault cleared by status access then ctrl write
// R17: while fault, enable and master sets ignored
// R18: word into full buffer sets overrun flag
// R19: overrun keeps old word, discards later ones
// R20: overrun cleared by data read, status read
// R21: received check differing sets mismatch flag
// R22: mismatch cleared only by writing zero
// R23: check enable set resets both accumulators
// R24: one interrupt from flags and their enables
module sdl_core #(
    parameter int WORD_BITS = sdl_pkg::SDL_WORD_BITS
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    // serial pins
    input  wire logic                 sck_pin,
    input  wire logic                 slave_select_pin,
    input  wire logic                 sdi_pin,
    output logic                      sdo_o,
    output logic                      sdo_oe,
    // control register one writes and mode levels
    input  wire logic                 ctrl1_wr,
    input  wire logic                 ctrl1_enable_wdata,
    input  wire logic                 ctrl1_master_wdata,
    input  wire logic                 ctrl1_check_wdata,
    input  wire logic                 hw_select_mode,
    input  wire logic                 internal_select_level,
    input  wire logic                 rx_only_mode,
    // control register two levels
    input  wire logic                 tx_dma_req_enable,
    input  wire logic                 rx_dma_req_enable,
    input  wire logic                 error_irq_enable,
    input  wire logic                 tx_empty_irq_enable,
    input  wire logic                 rx_full_irq_enable,
    // data and status access
    input  wire logic                 data_wr,
    input  wire logic [WORD_BITS-1:0] data_wdata,
    input  wire logic                 data_rd,
    output logic      [WORD_BITS-1:0] data_rdata,
    input  wire logic                 status_rd,
    input  wire logic                 status_wr,
    input  wire logic                 status_wr_mismatch,
    // dma
    output logic                      tx_dma_req,
    output logic                      rx_dma_req,
    input  wire logic                 dma_last_word,
    // state
    output logic                      interface_enable_bit,
    output logic                      master_select_bit,
    output logic                      check_calc_enable,
    output logic                      tx_buffer_empty_flag,
    output logic                      rx_buffer_full_flag,
    output logic                      transfer_busy_flag,
    output logic                      master_fault_flag,
    output logic                      overrun_flag,
    output logic                      check_mismatch_flag,
    output logic      [7:0]           tx_check_value,
    output logic      [7:0]           rx_check_value,
    output logic                      spi_irq
);
    import sdl_pkg::*;

    if (WORD_BITS != 8) begin : g_bad_width
        $error("sdl_core: check logic serves 8-bit words only");
    end

    sdl_link_if #(.W(WORD_BITS)) lk ();

    sdl_link_track #(.W(WORD_BITS)) u_link (
        .ref_clk          (ref_clk),
        .reset            (reset),
        .clk_en           (clk_en),
        .sck_pin          (sck_pin),
        .slave_select_pin (slave_select_pin),
        .sdi_pin          (sdi_pin),
        .sdo_o            (sdo_o),
        .sdo_oe           (sdo_oe),
        .lk               (lk)
    );

    logic                 en,        next_en;
    logic                 ms,        next_ms;
    logic                 chk_en,    next_chk_en;
    logic                 off_pend,  next_off_pend;
    logic                 tx_full,   next_tx_full;
    logic [WORD_BITS-1:0] tx_buf,    next_tx_buf;
    logic                 rx_full,   next_rx_full;
    logic [WORD_BITS-1:0] rx_buf,    next_rx_buf;
    logic                 fault,     next_fault;
    logic                 stat_seen, next_stat_seen;
    logic                 ovr,       next_ovr;
    logic                 rd_seen,   next_rd_seen;
    logic                 mism,      next_mism;
    logic [7:0]           tx_acc,    next_tx_acc;
    logic [7:0]           rx_acc,    next_rx_acc;
    logic                 busy,      next_busy;
    sdl_chk_e             chk,       next_chk;
    logic                 fault_cond;

    // select seen low while acting as master
    assign fault_cond = en & ms & (hw_select_mode ? lk.sel_low      // [R14]
                                                  : ~internal_select_level);

    always_comb begin
        next_en        = en;
        next_ms        = ms;
        next_chk_en    = chk_en;
        next_off_pend  = off_pend;
        next_tx_full   = tx_full;
        next_tx_buf    = tx_buf;
        next_rx_full   = rx_full;
        next_rx_buf    = rx_buf;
        next_fault     = fault;
        next_stat_seen = stat_seen;
        next_ovr       = ovr;
        next_rd_seen   = rd_seen;
        next_mism      = mism;
        next_tx_acc    = tx_acc;
        next_rx_acc    = rx_acc;
        next_chk       = chk;

        // control register one
        if (fault && (status_rd || status_wr)) begin
            next_stat_seen = 1'b1;
        end
        if (ctrl1_wr) begin
            if (stat_seen) begin
                next_fault     = 1'b0;                              // [R16]
                next_stat_seen = 1'b0;
            end
            next_en = ctrl1_enable_wdata & ~fault;                  // [R17]
            next_ms = ctrl1_master_wdata & ~fault;                  // [R17]
            next_off_pend = 1'b0;
            // slave receive-only stops only at word boundary
            if (en && !ctrl1_enable_wdata && !ms && rx_only_mode
                    && lk.in_word) begin
                next_en       = 1'b1;                               // [R08]
                next_off_pend = 1'b1;
            end
            next_chk_en = ctrl1_check_wdata;
            if (ctrl1_check_wdata && !chk_en) begin
                next_tx_acc = SDL_CHECK_INIT;                       // [R23]
                next_rx_acc = SDL_CHECK_INIT;
            end
        end else if (off_pend && !lk.in_word) begin
            next_en       = 1'b0;                                   // [R08]
            next_off_pend = 1'b0;
        end
        if (fault_cond) begin
            next_fault    = 1'b1;                                   // [R14]
            next_en       = 1'b0;                                   // [R15]
            next_ms       = 1'b0;                                   // [R15]
            next_off_pend = 1'b0;
        end

        // transmit side
        if (lk.tx_take) begin
            next_tx_full = 1'b0;                                    // [R09]
            if (chk != SDL_CHK_LOADED) begin
                next_tx_acc = sdl_check_step(tx_acc, tx_buf);
            end
        end
        if (data_wr) begin
            next_tx_full = 1'b1;                                    // [R09]
            next_tx_buf  = data_wdata;
        end

        // receive side
        if (data_rd) begin
            next_rx_full = 1'b0;                                    // [R10]
            next_rd_seen = 1'b1;
        end
        if (status_rd && rd_seen) begin
            next_ovr     = 1'b0;                                    // [R20]
            next_rd_seen = 1'b0;
        end
        if (status_wr && !status_wr_mismatch) begin
            next_mism = 1'b0;                                       // [R22]
        end
        if (lk.word_done && chk != SDL_CHK_XFER) begin
            next_rx_acc = sdl_check_step(rx_acc, lk.rx_word);
            if (rx_full || ovr) begin
                next_ovr = rx_full | ovr;                           // [R18]
            end else begin
                next_rx_full = 1'b1;                                // [R10]
                next_rx_buf  = lk.rx_word;                          // [R19]
            end
        end

        // automatic check word exchange
        unique case (chk)
            SDL_CHK_IDLE: begin
                if (dma_last_word && chk_en
                        && (tx_dma_req_enable || rx_dma_req_enable)) begin
                    next_chk = SDL_CHK_ARMED;                       // [R05]
                end
            end
            SDL_CHK_ARMED: begin
                if (!tx_full && !data_wr) begin
                    next_tx_full = 1'b1;                            // [R05]
                    next_tx_buf  = tx_acc;
                    next_chk     = SDL_CHK_LOADED;
                end
            end
            SDL_CHK_LOADED: begin
                if (lk.tx_take) begin
                    next_chk = SDL_CHK_XFER;
                end
            end
            SDL_CHK_XFER: begin
                if (lk.word_done) begin
                    if (lk.rx_word != rx_acc) begin
                        next_mism = 1'b1;                           // [R21]
                    end
                    next_chk = SDL_CHK_IDLE;
                end
            end
            default: next_chk = SDL_CHK_IDLE;
        endcase
        if (!en) begin
            next_chk = SDL_CHK_IDLE;
        end
    end

    // busy: master outside rx-only holds while words queue, slave only inside a word
    always_comb begin
        if (!en || fault_cond) begin
            next_busy = 1'b0;                                       // [R12]
        end else if (ms) begin
            next_busy = ~rx_only_mode & (tx_full | lk.in_word);     // [R11] [R13]
        end else begin
            next_busy = lk.in_word;                                 // [R13]
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            en        <= 1'b0;
            ms        <= 1'b0;
            chk_en    <= 1'b0;
            off_pend  <= 1'b0;
            tx_full   <= 1'b0;
            tx_buf    <= '0;
            rx_full   <= 1'b0;
            rx_buf    <= '0;
            fault     <= 1'b0;
            stat_seen <= 1'b0;
            ovr       <= 1'b0;
            rd_seen   <= 1'b0;
            mism      <= 1'b0;
            tx_acc    <= SDL_CHECK_INIT;
            rx_acc    <= SDL_CHECK_INIT;
            busy      <= 1'b0;
            chk       <= SDL_CHK_IDLE;
        end else if (clk_en) begin
            en        <= next_en;
            ms        <= next_ms;
            chk_en    <= next_chk_en;
            off_pend  <= next_off_pend;
            tx_full   <= next_tx_full;
            tx_buf    <= next_tx_buf;
            rx_full   <= next_rx_full;
            rx_buf    <= next_rx_buf;
            fault     <= next_fault;
            stat_seen <= next_stat_seen;
            ovr       <= next_ovr;
            rd_seen   <= next_rd_seen;
            mism      <= next_mism;
            tx_acc    <= next_tx_acc;
            rx_acc    <= next_rx_acc;
            busy      <= next_busy;
            chk       <= next_chk;
        end
    end

    assign lk.enable   = en;
    assign lk.master   = ms;
    assign lk.tx_valid = tx_full;
    assign lk.tx_word  = tx_buf;

    assign tx_dma_req = en & tx_dma_req_enable & ~tx_full           // [R02] [R04]
                      & (chk == SDL_CHK_IDLE);
    assign rx_dma_req = en & rx_dma_req_enable & rx_full;           // [R03] [R04]
    assign spi_irq    = (tx_empty_irq_enable & ~tx_full)            // [R24]
                      | (rx_full_irq_enable & rx_full)
                      | (error_irq_enable & (fault | ovr | mism));  // [R24]

    assign data_rdata           = rx_buf;
    assign interface_enable_bit = en;
    assign master_select_bit    = ms;
    assign check_calc_enable    = chk_en;
    assign tx_buffer_empty_flag = ~tx_full;
    assign rx_buffer_full_flag  = rx_full;
    assign transfer_busy_flag   = busy;
    assign master_fault_flag    = fault;
    assign overrun_flag         = ovr;
    assign check_mismatch_flag  = mism;
    assign tx_check_value       = tx_acc;
    assign rx_check_value       = rx_acc;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_tx_req_drop;
        clk_en && data_wr |=> !tx_dma_req;
    endproperty
    a_tx_req_drop: assert property (p_tx_req_drop)                  // [R02]
        else $error("tx dma request stayed after data write");

    property p_rx_req_rise;
        clk_en && en && rx_dma_req_enable && lk.word_done && !rx_full && !ovr
            && !data_rd && chk != SDL_CHK_XFER |=> rx_dma_req;
    endproperty
    a_rx_req_rise: assert property (p_rx_req_rise)                  // [R03]
        else $error("rx dma request missing after word stored");

    property p_rx_clear;
        clk_en && data_rd && !lk.word_done |=> !rx_buffer_full_flag;
    endproperty
    a_rx_clear: assert property (p_rx_clear)                        // [R10]
        else $error("rx full not cleared by data read");

    property p_fault_effect;
        clk_en && fault_cond |=> master_fault_flag && !interface_enable_bit
            && !master_select_bit ##1 !transfer_busy_flag || !clk_en;
    endproperty
    a_fault_effect: assert property (p_fault_effect)                // [R15]
        else $error("master fault did not shut the interface");

    property p_fault_blocks;
        clk_en && fault && ctrl1_wr |=> !interface_enable_bit;
    endproperty
    a_fault_blocks: assert property (p_fault_blocks)                // [R17]
        else $error("enable set while master fault pending");

    property p_overrun_set;
        clk_en && lk.word_done && rx_full && !data_rd
            && chk != SDL_CHK_XFER |=> overrun_flag;
    endproperty
    a_overrun_set: assert property (p_overrun_set)                  // [R18]
        else $error("overrun flag missing");

    property p_overrun_keep;
        overrun_flag && !status_rd |=> $stable(data_rdata);
    endproperty
    a_overrun_keep: assert property (p_overrun_keep)                // [R19]
        else $error("receive word replaced during overrun");

    property p_mism_hold;
        check_mismatch_flag && !(status_wr && !status_wr_mismatch)
            |=> check_mismatch_flag;
    endproperty
    a_mism_hold: assert property (p_mism_hold)                      // [R22]
        else $error("check mismatch flag lost without write of zero");

    property p_busy_off;
        clk_en && !en ##1 clk_en |-> !transfer_busy_flag;
    endproperty
    a_busy_off: assert property (p_busy_off)                        // [R12]
        else $error("busy high while disabled");
endmodule : sdl_core
`default_nettype wire

// ### rtl/sdl_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sdl_link_if #(parameter int W = 8);
    logic         enable;
    logic         master;
    logic         tx_valid;
    logic [W-1:0] tx_word;
    logic         tx_take;
    logic         word_done;
    logic [W-1:0] rx_word;
    logic         in_word;
    logic         sel_low;

    modport core (output enable, master, tx_valid, tx_word,
                  input  tx_take, word_done, rx_word, in_word, sel_low);
    modport link (input  enable, master, tx_valid, tx_word,
                  output tx_take, word_done, rx_word, in_word, sel_low);
endinterface : sdl_link_if
`default_nettype wire

// ### rtl/sdl_link_track.sv
`timescale 1ns/1ns
`default_nettype none
module sdl_link_track #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // serial pins
    input  wire logic sck_pin,
    input  wire logic slave_select_pin,
    input  wire logic sdi_pin,
    output logic      sdo_o,
    output logic      sdo_oe,
    // toward the core
    sdl_link_if.link  lk
);
    import sdl_pkg::*;
    localparam int CW = $clog2(W);

    logic [2:0]    sck_q,  next_sck_q;
    logic [1:0]    sel_q,  next_sel_q;
    logic [1:0]    sdi_q,  next_sdi_q;
    logic [CW-1:0] cnt,    next_cnt;
    logic [W-1:0]  rx_sh,  next_rx_sh;
    logic [W-1:0]  tx_sh,  next_tx_sh;
    logic          loaded, next_loaded;
    logic          done,   next_done;
    logic          oe,     next_oe;
    logic          rise, fall, active, take;

    if (W < 2) begin : g_bad_width
        $error("sdl_link_track: W must be at least 2");
    end

    // edges only from the second stage onward
    assign rise   = sck_q[1] & ~sck_q[2];
    assign fall   = ~sck_q[1] & sck_q[2];
    assign active = lk.enable & (lk.master | ~sel_q[1]);
    assign take   = active & ~loaded & lk.tx_valid & (cnt == '0) & ~rise;

    always_comb begin
        next_sck_q  = {sck_q[1:0], sck_pin};
        next_sel_q  = {sel_q[0], slave_select_pin};
        next_sdi_q  = {sdi_q[0], sdi_pin};
        next_cnt    = cnt;
        next_rx_sh  = rx_sh;
        next_tx_sh  = tx_sh;
        next_loaded = loaded;
        next_done   = 1'b0;
        next_oe     = active;
        if (!active) begin
            next_cnt    = '0;
            next_loaded = 1'b0;
        end else begin
            if (take) begin
                next_tx_sh  = lk.tx_word;
                next_loaded = 1'b1;
            end
            if (rise) begin
                next_rx_sh = {rx_sh[W-2:0], sdi_q[1]};
                if (cnt == CW'(W - 1)) begin
                    next_cnt    = '0;
                    next_done   = 1'b1;
                    next_loaded = 1'b0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            if (fall && cnt != '0) begin
                next_tx_sh = {tx_sh[W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sck_q  <= '0;
            sel_q  <= 2'h3;
            sdi_q  <= '0;
            cnt    <= '0;
            rx_sh  <= '0;
            tx_sh  <= '0;
            loaded <= 1'b0;
            done   <= 1'b0;
            oe     <= 1'b0;
        end else if (clk_en) begin
            sck_q  <= next_sck_q;
            sel_q  <= next_sel_q;
            sdi_q  <= next_sdi_q;
            cnt    <= next_cnt;
            rx_sh  <= next_rx_sh;
            tx_sh  <= next_tx_sh;
            loaded <= next_loaded;
            done   <= next_done;
            oe     <= next_oe;
        end
    end

    assign lk.tx_take   = take & clk_en;
    assign lk.word_done = done;
    assign lk.rx_word   = rx_sh;
    assign lk.in_word   = (cnt != '0);
    assign lk.sel_low   = ~sel_q[1];
    assign sdo_o        = tx_sh[W-1];
    assign sdo_oe       = oe;
endmodule : sdl_link_track
`default_nettype wire

// ### rtl/sdl_pkg.sv
package sdl_pkg;

    localparam int         SDL_WORD_BITS  = 8;
    localparam logic [7:0] SDL_CHECK_POLY = 8'h07;
    localparam logic [7:0] SDL_CHECK_INIT = 8'h00;

    typedef enum logic [3:0] {
        SDL_CHK_IDLE   = 4'b0001,
        SDL_CHK_ARMED  = 4'b0010,
        SDL_CHK_LOADED = 4'b0100,
        SDL_CHK_XFER   = 4'b1000
    } sdl_chk_e;

    // one word into a check accumulator, msb first
    function automatic logic [7:0] sdl_check_step(input logic [7:0] acc,
                                                   input logic [7:0] word);
        logic [7:0] c;
        c = acc;
        for (int i = 7; i >= 0; i--) begin
            if (c[7] ^ word[i]) begin
                c = {c[6:0], 1'b0} ^ SDL_CHECK_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : sdl_check_step

endpackage : sdl_pkg
